// ==== dv/pilc_ctrl_assertions.sv ====
// Port checks for the isolate/loopback control: handshakes, fixed outputs, reset.
// Assumes it is bound to pilc_ctrl and sees only that module's ports.
`timescale 1ns/100ps
`include "pilc_map.svh"
module pilc_ctrl_assertions
    import pilc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = `PILC_PHYAD_DEF
) (
    input wire logic                clk_sys,
    input wire logic                srst,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic                gmii_rx_dv,
    input wire logic                pcs_tx_gmii_en,
    input wire logic [1:0]          gt_loopback,
    input wire logic [4:0]          phy_addr,
    input wire pilc_pkg::pilc_std_e std_sel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_gt_loop_off: assert property (gt_loopback == `PILC_GT_LOOP_OFF)
        else $error("transceiver loopback select not zero");
    a_phy_addr_fixed: assert property (!$past(srst) |-> phy_addr == PHY_ADDR)
        else $error("phy address differs from its parameter");
    a_reset_quiet: assert property ($fell(srst) |-> !gmii_rx_dv && !pcs_tx_gmii_en)
        else $error("gmii active straight after reset");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == `PILC_RESP_SLVERR |->
        s_axi_rdata == 32'h0) else $error("refused read carries data");
    a_std_by_write: assert property ($changed(std_sel) |-> s_axi_bvalid || $past(s_axi_bvalid)
        || $past(s_axi_bvalid, 2)) else $error("standard changed without a write");
endmodule // pilc_ctrl_assertions

bind pilc_ctrl pilc_ctrl_assertions #(.PHY_ADDR(PHY_ADDR)) u_pilc_chk (.*);

// ==== dv/pilc_mac_model.sv ====
// Client MAC stand-in: sends random frames on the GMII transmit side.
// Assumes same clock as the block; receive side is judged by the bench.
`timescale 1ns/100ps
module pilc_mac_model (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    output logic [7:0]      gmii_txd = 8'h0,
    output logic            gmii_tx_en = 1'b0,
    output logic            gmii_tx_er = 1'b0
);
    logic [5:0] gap_r = 6'h0;
    always @(posedge clk_sys) begin
        gap_r <= gap_r + 6'h1;
        gmii_tx_en <= !srst && gap_r[5];
        gmii_tx_er <= !srst && gap_r[5] && gap_r[4:0] == 5'h11;
        // Idle bytes flip so stale data never looks valid
        gmii_txd <= gap_r[5] ? 8'($urandom) : ~gmii_txd;
    end
endmodule // pilc_mac_model

// ==== dv/tb_pilc_ctrl.sv ====
// Self-checking bench for the isolate/loopback control with random datapaths.
// Assumes the transceiver build with management and both standards.
`timescale 1ns/100ps
`include "pilc_map.svh"
module tb_pilc_ctrl;
    import pilc_pkg::*;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic        clk_sys = 1'b0, srst = 1'b1, k_last = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, ab;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tbi_wrap;
    logic [1:0]  s_axi_bresp, s_axi_rresp, gt_loopback;
    logic        cfg_vec_valid = 1'b0, cfg_vec_isolate = 1'b1, cfg_vec_loopback = 1'b0;
    logic [15:0] cfg_vec_ability = '0;
    logic [7:0]  gmii_txd, gmii_rxd, pcs_tx_gmii_d, line_tx_data, pcs_rx_data;
    logic [7:0]  pcs_tx_data = '0, line_rx_data = '0, pcs_rx_gmii_d = '0;
    logic        pcs_tx_is_k = 1'b0, line_rx_is_k = 1'b0, pcs_rx_gmii_dv = 1'b0;
    logic        pcs_rx_gmii_er = 1'b0, gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er;
    logic        pcs_tx_gmii_en, pcs_tx_gmii_er, line_tx_is_k, pcs_rx_is_k;
    logic [4:0]  phy_addr;
    pilc_std_e   std_sel;
    logic [37:0] p_in;
    int          mode = -1, failures = 0, tests_run = 0;
    wire logic [37:0] in_now = {gmii_txd, gmii_tx_en, gmii_tx_er, pcs_tx_data, pcs_tx_is_k,
        line_rx_data, line_rx_is_k, pcs_rx_gmii_d, pcs_rx_gmii_dv, pcs_rx_gmii_er};
    wire logic [37:0] out_now = {gmii_rxd, gmii_rx_dv, gmii_rx_er, pcs_tx_gmii_d, pcs_tx_gmii_en,
        pcs_tx_gmii_er, line_tx_data, line_tx_is_k, pcs_rx_data, pcs_rx_is_k};

    pilc_ctrl #(.PHY_ADDR(5'h1f)) dut (.*);
    pilc_mac_model u_mac (.*);

    always #2.5 clk_sys = ~clk_sys;

    // Mode 0 isolated, 1 normal, 2 loopback; k is the Idle phase due now
    function automatic logic [37:0] exp_out(input int m, input logic [37:0] i, input logic k);
        logic [8:0] lt;
        lt = (m == 2) ? {k ? `PILC_IDLE_K : `PILC_IDLE_D, k} : i[27:19];
        return {(m == 0) ? 20'h0 : {i[9:0], i[37:28]}, lt, (m == 2) ? i[27:19] : i[18:10]};
    endfunction

    function automatic logic [31:0] st(input logic i, input logic l, input logic s);
        return {29'h0, s, l, i};
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        check(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                          input logic [31:0] m);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        check({s_axi_rdata & m, s_axi_rresp}, {e, er}, "read data");
        s_axi_rready <= 1'b0;
    endtask

    task automatic go(input int m, input logic [11:0] a, input logic [15:0] d, input string t);
        mode = -1;
        axi_wr(a, {16'h0, d}, `PILC_RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        mode = m;
        repeat (30) @(posedge clk_sys);
        $display("test %s done", t);
    endtask

    // Vector settles well before its valid edge; the sync has no other qualifier
    task automatic vec_drive(input logic i, input logic l, input logic [15:0] v);
        {cfg_vec_isolate, cfg_vec_loopback, cfg_vec_ability} <= {i, l, v};
        repeat (4) @(posedge clk_sys);
        cfg_vec_valid <= 1'b1;
        repeat (8) @(posedge clk_sys);
        cfg_vec_valid <= 1'b0;
    endtask

    task automatic vec(input int m, input logic i, input logic l, input logic [15:0] v,
                       input string t);
        mode = -1;
        vec_drive(i, l, v);
        axi_rd(`PILC_OFF_ABILITY, {16'h0, v}, `PILC_RESP_OKAY, ALL);
        axi_rd(`PILC_OFF_STATUS, st(i, l, 1'b0), `PILC_RESP_OKAY, 32'hf);
        mode = m;
        repeat (30) @(posedge clk_sys);
        $display("test %s done", t);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        p_in <= in_now;
        {pcs_tx_data, pcs_tx_is_k, line_rx_data, line_rx_is_k, pcs_rx_gmii_d, pcs_rx_gmii_dv,
            pcs_rx_gmii_er} <= 28'($urandom);
    end

    always @(negedge clk_sys) begin
        if (mode >= 0)
            check(out_now, exp_out(mode, p_in, ~k_last), "data path");
        k_last = line_tx_is_k;
    end

    initial begin
        #20us;
        failures++;
        $display("wrong value at %0t: watchdog", $time);
        tally_and_finish;
    end

    initial begin
        void'($urandom(50));
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        mode = 0;
        axi_rd(`PILC_OFF_CTRL, 32'h400, `PILC_RESP_OKAY, ALL);
        axi_rd(`PILC_OFF_ABILITY, 32'h20, `PILC_RESP_OKAY, ALL);
        axi_rd(`PILC_OFF_STATUS, st(1'b1, 1'b0, 1'b0), `PILC_RESP_OKAY, 32'hf);
        check({phy_addr, gt_loopback}, {5'h1f, 2'h0}, "fixed outputs");
        $display("test reset done");
        go(1, `PILC_OFF_CTRL, 16'h0000, "isolate clear");
        go(2, `PILC_OFF_CTRL, 16'h4000, "loopback");
        axi_rd(`PILC_OFF_STATUS, st(1'b0, 1'b1, 1'b0), `PILC_RESP_OKAY, 32'hf);
        check(tbi_wrap, 1'b0, "wrap in transceiver build");
        go(0, `PILC_OFF_CTRL, 16'h0400, "isolate again");
        go(0, `PILC_OFF_CFGSRC, 16'h0001, "standard sgmii");
        check(std_sel, PILC_STD_SGMII, "standard");
        go(0, `PILC_OFF_CFGSRC, 16'h0000, "standard basex");
        check(std_sel, PILC_STD_BASEX, "standard");
        axi_wr(12'h100, $urandom, `PILC_RESP_SLVERR);
        axi_rd(12'h100, 32'h0, `PILC_RESP_SLVERR, ALL);
        axi_rd(`PILC_OFF_CTRL, 32'h400, `PILC_RESP_OKAY, ALL);
        for (int n = 0; n < 4; n++) begin
            ab = $urandom;
            axi_wr(`PILC_OFF_ABILITY, ab, `PILC_RESP_OKAY);
            axi_rd(`PILC_OFF_ABILITY, {16'h0, ab[15:0]}, `PILC_RESP_OKAY, ALL);
        end
        $display("test unmapped and ability done");
        ab = $urandom;
        vec(2, 1'b0, 1'b1, ab[15:0], "vector loopback");
        // Management-only source must ignore a vector edge
        go(2, `PILC_OFF_CFGSRC, 16'h0002, "source mdio only");
        axi_rd(`PILC_OFF_CFGSRC, 32'h2, `PILC_RESP_OKAY, ALL);
        vec_drive(1'b1, 1'b0, ~ab[15:0]);
        axi_rd(`PILC_OFF_ABILITY, {16'h0, ab[15:0]}, `PILC_RESP_OKAY, ALL);
        axi_rd(`PILC_OFF_STATUS, st(1'b0, 1'b1, 1'b0), `PILC_RESP_OKAY, 32'hf);
        go(2, `PILC_OFF_CFGSRC, 16'h0000, "source both");
        vec(0, 1'b1, 1'b0, 16'hffff, "vector isolate");
        tally_and_finish;
    end
endmodule // tb_pilc_ctrl

// ==== rtl/pilc_ctrl.sv ====
// Isolate, loopback and standard select control with AXI4-Lite registers.
// Assumes GMII and PCS data are on clk_sys; config vector from another domain.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "pilc_map.svh"
// How it works
// - After reset the block is isolated until isolate is cleared.
// - Loopback follows the management register or the static vector.
// - Ten-bit build: loopback drives the wrap request high.
// - Transceiver build: transmit data fed to receive just before transceiver.
// - During transceiver loopback, Idles go to the transceiver.
// - Transceiver loopback select output stays at 00.
// - PHY address is five bits, 0 to 31.
// - Dual-standard build switches 1000BASE-X/SGMII on a register write.
// - Vector input also writes registers 0 and 4.
module pilc_ctrl
    import pilc_pkg::*;
#(
    parameter bit          HAS_MGMT  = 1'b1,
    parameter bit          IS_TBI    = 1'b0,
    parameter bit          HAS_BOTH  = 1'b1,
    parameter logic [4:0]  PHY_ADDR  = `PILC_PHYAD_DEF
) (
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  cfg_vec_valid,
    input  wire logic                  cfg_vec_isolate,
    input  wire logic                  cfg_vec_loopback,
    input  wire logic [15:0]           cfg_vec_ability,
    input  wire logic [7:0]            gmii_txd,
    input  wire logic                  gmii_tx_en,
    input  wire logic                  gmii_tx_er,
    output logic [7:0]                 gmii_rxd,
    output logic                       gmii_rx_dv,
    output logic                       gmii_rx_er,
    input  wire logic [7:0]            pcs_tx_data,
    input  wire logic                  pcs_tx_is_k,
    input  wire logic [7:0]            line_rx_data,
    input  wire logic                  line_rx_is_k,
    input  wire logic [7:0]            pcs_rx_gmii_d,
    input  wire logic                  pcs_rx_gmii_dv,
    input  wire logic                  pcs_rx_gmii_er,
    output logic [7:0]                 pcs_tx_gmii_d,
    output logic                       pcs_tx_gmii_en,
    output logic                       pcs_tx_gmii_er,
    output logic [7:0]                 line_tx_data,
    output logic                       line_tx_is_k,
    output logic [7:0]                 pcs_rx_data,
    output logic                       pcs_rx_is_k,
    output logic                       tbi_wrap,
    output logic [1:0]                 gt_loopback,
    output logic [4:0]                 phy_addr,
    output pilc_pkg::pilc_std_e        std_sel
);
    import pilc_pkg::*;

    pilc_reg_t    ctrl_r;
    pilc_reg_t    abil_r;
    logic         std_r;
    pilc_cfgsrc_e src_r;
    logic [2:0]   vsync_r;
    logic         viso_m_r, viso_r, vloop_m_r, vloop_r;
    logic [15:0]  vabil_m_r, vabil_r;
    logic         aw_got_r, w_got_r;
    logic [11:0]  awaddr_r;
    logic [31:0]  wdata_r;
    logic [3:0]   wstrb_r;
    logic         wr_fire;
    logic         vec_load;
    logic         iso, loop;
    logic [7:0]   idle_data;
    logic         idle_is_k;

    // Two-flop sync of the static vector; it may come from a slower domain
    always_ff @(posedge clk_sys) begin
        viso_m_r  <= cfg_vec_isolate;
        viso_r    <= viso_m_r;
        vloop_m_r <= cfg_vec_loopback;
        vloop_r   <= vloop_m_r;
        vabil_m_r <= cfg_vec_ability;
        vabil_r   <= vabil_m_r;
        vsync_r   <= {vsync_r[1:0], cfg_vec_valid};
    end
    assign vec_load = vsync_r[1] & ~vsync_r[2];

    // Write address and data taken in either order, response after both
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PILC_RESP_OKAY;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                case (awaddr_r)
                    `PILC_OFF_CTRL, `PILC_OFF_ABILITY, `PILC_OFF_CFGSRC:
                        s_axi_bresp <= `PILC_RESP_OKAY;
                    `PILC_OFF_STATUS: s_axi_bresp <= `PILC_RESP_OKAY;
                    default: s_axi_bresp <= `PILC_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register writes; vector load wins a same-cycle clash as the later source
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_r <= `PILC_CTRL_RST;
            abil_r <= `PILC_ABIL_RST;
            std_r  <= 1'b0;
            src_r  <= HAS_MGMT ? PILC_CFG_BOTH : PILC_CFG_VEC;
        end else begin
            if (wr_fire && HAS_MGMT) begin
                case (awaddr_r)
                    `PILC_OFF_CTRL: begin
                        if (wstrb_r[0]) ctrl_r[7:0]  <= wdata_r[7:0];
                        if (wstrb_r[1]) ctrl_r[15:8] <= wdata_r[15:8];
                    end
                    `PILC_OFF_ABILITY: begin
                        if (wstrb_r[0]) abil_r[7:0]  <= wdata_r[7:0];
                        if (wstrb_r[1]) abil_r[15:8] <= wdata_r[15:8];
                    end
                    `PILC_OFF_CFGSRC: begin
                        if (wstrb_r[0] && HAS_BOTH) std_r <= wdata_r[`PILC_STD_BIT];
                        if (wstrb_r[0] && wdata_r[2:1] != 2'b11) begin
                            src_r <= pilc_cfgsrc_e'(wdata_r[2:1]);
                        end
                    end
                    default: ;
                endcase
            end
            if (vec_load && src_r != PILC_CFG_MDIO) begin
                ctrl_r[`PILC_CTRL_ISO_BIT]  <= viso_r;
                ctrl_r[`PILC_CTRL_LOOP_BIT] <= vloop_r;
                abil_r                      <= vabil_r;
            end
        end
    end

    assign iso  = ctrl_r[`PILC_CTRL_ISO_BIT];
    assign loop = ctrl_r[`PILC_CTRL_LOOP_BIT];

    // Read channel, one-cycle answer held until rready
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `PILC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PILC_RESP_OKAY;
            case (s_axi_araddr)
                `PILC_OFF_CTRL:    s_axi_rdata <= {16'h0000, ctrl_r};
                `PILC_OFF_ABILITY: s_axi_rdata <= {16'h0000, abil_r};
                `PILC_OFF_STATUS:  s_axi_rdata <= {28'h0000000, tbi_wrap, std_r, loop, iso};
                `PILC_OFF_CFGSRC:  s_axi_rdata <= {29'h0000000, src_r, std_r};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `PILC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Strap-like outputs, with the standard select and wrap request registered alongside
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gt_loopback <= `PILC_GT_LOOP_OFF;
            phy_addr    <= `PILC_PHYAD_DEF;
            std_sel     <= PILC_STD_BASEX;
            tbi_wrap    <= 1'b0;
        end else begin
            gt_loopback <= `PILC_GT_LOOP_OFF;
            phy_addr    <= PHY_ADDR;
            std_sel     <= pilc_std_e'(std_r);
            tbi_wrap    <= IS_TBI & loop;
        end
    end

    pilc_idle_gen u_idle (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .en        (loop && !IS_TBI),
        .idle_data (idle_data),
        .idle_is_k (idle_is_k)
    );

    // Datapath gating and loopback mux; registered so outputs come from flops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gmii_rxd       <= '0;
            gmii_rx_dv     <= 1'b0;
            gmii_rx_er     <= 1'b0;
            pcs_tx_gmii_d  <= '0;
            pcs_tx_gmii_en <= 1'b0;
            pcs_tx_gmii_er <= 1'b0;
            line_tx_data   <= `PILC_IDLE_K;
            line_tx_is_k   <= 1'b1;
            pcs_rx_data    <= '0;
            pcs_rx_is_k    <= 1'b0;
        end else begin
            gmii_rxd       <= iso ? 8'h00 : pcs_rx_gmii_d;
            gmii_rx_dv     <= ~iso & pcs_rx_gmii_dv;
            gmii_rx_er     <= ~iso & pcs_rx_gmii_er;
            pcs_tx_gmii_d  <= iso ? 8'h00 : gmii_txd;
            pcs_tx_gmii_en <= ~iso & gmii_tx_en;
            pcs_tx_gmii_er <= ~iso & gmii_tx_er;
            if (loop && !IS_TBI) begin
                line_tx_data <= idle_data;
                line_tx_is_k <= idle_is_k;
                pcs_rx_data  <= pcs_tx_data;
                pcs_rx_is_k  <= pcs_tx_is_k;
            end else begin
                line_tx_data <= pcs_tx_data;
                line_tx_is_k <= pcs_tx_is_k;
                pcs_rx_data  <= line_rx_data;
                pcs_rx_is_k  <= line_rx_is_k;
            end
        end
    end
endmodule // pilc_ctrl

// ==== rtl/pilc_idle_gen.sv ====
// Idle ordered-set generator for the transceiver side during loopback.
// Assumes one clock, synchronous active-high reset, enable from the same domain.
`timescale 1ns/100ps
`include "pilc_map.svh"
module pilc_idle_gen (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       en,
    output logic [7:0]      idle_data,
    output logic            idle_is_k
);
    logic phase_r;

    // Alternate K28.5 and D16.2 so the stream keeps a valid idle pattern
    // Parked on K with D due next, so enabling never sends two K in a row
    always_ff @(posedge clk_sys) begin
        if (srst || !en) begin
            phase_r <= 1'b1;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !en) begin
            idle_data <= `PILC_IDLE_K;
            idle_is_k <= 1'b1;
        end else begin
            idle_data <= phase_r ? `PILC_IDLE_D : `PILC_IDLE_K;
            idle_is_k <= ~phase_r;
        end
    end
endmodule // pilc_idle_gen

// ==== rtl/pilc_map.svh ====
// Register map, field positions, reset values and codes for the isolate/loopback control.
// Assumes it is included by the package, the design files, the bench and the assertion module.
`ifndef PILC_MAP_SVH
`define PILC_MAP_SVH
`define PILC_OFF_CTRL      12'h000
`define PILC_OFF_ABILITY   12'h010
`define PILC_OFF_STATUS    12'h020
`define PILC_OFF_CFGSRC    12'h030
`define PILC_CTRL_LOOP_BIT 14
`define PILC_CTRL_ISO_BIT  10
`define PILC_CTRL_RST      16'h0400
`define PILC_ABIL_RST      16'h0020
`define PILC_STD_BIT       0
`define PILC_ST_ISO_BIT    0
`define PILC_ST_LOOP_BIT   1
`define PILC_ST_STD_BIT    2
`define PILC_ST_WRAP_BIT   3
`define PILC_IDLE_K        8'hbc
`define PILC_IDLE_D        8'h50
`define PILC_GT_LOOP_OFF   2'h0
`define PILC_RESP_OKAY     2'h0
`define PILC_RESP_SLVERR   2'h2
`define PILC_PHYAD_DEF     5'h01
`endif

// ==== rtl/pilc_pkg.sv ====
// Types shared by the isolate/loopback control files.
// Assumes pilc_map.svh is on the include path.
`include "pilc_map.svh"
package pilc_pkg;
    typedef logic [4:0]  pilc_phyad_t;
    typedef logic [15:0] pilc_reg_t;
    typedef enum logic [0:0] {
        PILC_STD_BASEX = 1'b0,
        PILC_STD_SGMII = 1'b1
    } pilc_std_e;
    typedef enum logic [1:0] {
        PILC_CFG_BOTH = 2'b00,
        PILC_CFG_MDIO = 2'b01,
        PILC_CFG_VEC  = 2'b10
    } pilc_cfgsrc_e;
endpackage
